/* rtl/iface_clk_ctrl.sv */
// decode of clocking mode, interface clock pins and transmit power-down
`timescale 1ns/1ps
`include "spcfg_cfg.svh"
module iface_clk_ctrl (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // configuration fields and the full duplex interface pin
  input wire logic [2:0] i_clk_mode,
  input wire logic i_pin_two_clock_output_enable,
  input wire logic i_invert_pin_three,
  input wire logic [2:0] i_tx_analog,
  input wire logic i_full_duplex_interface,
  // interface clock source
  input wire logic i_iface_clk,
  // decoded outputs
  output logic [3:0] o_mode_number,
  output logic o_mode_unused,
  output logic o_interface_pin_two,
  output logic o_interface_pin_two_oe_n,
  output logic o_interface_pin_three,
  output logic o_tx_a_power_down,
  output logic o_tx_b_power_down,
  output logic o_tx_support_power_down,
  output logic o_dac_bias_enable
);
  typedef struct packed {
    logic [3:0] mode_num;
    logic unused;
    logic pin2;
    logic pin2_oe_n;
    logic pin3;
    logic txa;
    logic txb;
    logic sup;
    logic bias;
  } ctrl_state_t;

  // pin two released and bias on from reset
  localparam ctrl_state_t CTRL_RST = '{
    mode_num: `CFG_MODENUM_STANDARD, unused: 1'b0, pin2: 1'b0,
    pin2_oe_n: 1'b1, pin3: 1'b0, txa: 1'b0, txb: 1'b0, sup: 1'b0,
    bias: 1'b1};

  ctrl_state_t s_r;
  ctrl_state_t s_nxt;

  function automatic logic [3:0] mode_number(input logic [2:0] code);
    case (code)
      `CFG_MODE_STANDARD: mode_number = `CFG_MODENUM_STANDARD;
      `CFG_MODE_OPT_FULL: mode_number = `CFG_MODENUM_OPT_FULL;
      `CFG_MODE_OPT_HALF24: mode_number = `CFG_MODENUM_OPT_HALF24;
      `CFG_MODE_OPT_HALF12: mode_number = `CFG_MODENUM_OPT_HALF12;
      `CFG_MODE_CLONE: mode_number = `CFG_MODENUM_CLONE;
      default: mode_number = `CFG_MODENUM_UNUSED;
    endcase
  endfunction

  always_comb begin
    s_nxt = s_r;
    s_nxt.mode_num = mode_number(i_clk_mode);
    // unused codes are flagged, not trapped; the host must avoid them
    s_nxt.unused = (mode_number(i_clk_mode) == `CFG_MODENUM_UNUSED);
    s_nxt.pin2_oe_n = !i_pin_two_clock_output_enable;
    s_nxt.pin2 = i_iface_clk ^
      (i_pin_two_clock_output_enable && i_full_duplex_interface);
    s_nxt.pin3 = i_iface_clk ^ i_invert_pin_three;
    s_nxt.txa = (i_tx_analog == `CFG_TX_PD_A) ||
                (i_tx_analog == `CFG_TX_PD_BOTH);
    s_nxt.txb = (i_tx_analog == `CFG_TX_PD_B) ||
                (i_tx_analog == `CFG_TX_PD_BOTH);
    s_nxt.sup = (i_tx_analog == `CFG_TX_PD_BOTH);
    // bias stays on so outputs recover in a few cycles
    s_nxt.bias = 1'b1;
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s_r <= CTRL_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_mode_number = s_r.mode_num;
  assign o_mode_unused = s_r.unused;
  assign o_interface_pin_two = s_r.pin2;
  assign o_interface_pin_two_oe_n = s_r.pin2_oe_n;
  assign o_interface_pin_three = s_r.pin3;
  assign o_tx_a_power_down = s_r.txa;
  assign o_tx_b_power_down = s_r.txb;
  assign o_tx_support_power_down = s_r.sup;
  assign o_dac_bias_enable = s_r.bias;
endmodule

/* rtl/serial_port_clock_power_config_regs.sv */
// configuration registers 0x00 to 0x02 behind the serial control port
`timescale 1ns/1ps
`include "spcfg_cfg.svh"
// Summary of operation
// - bidir bit low: separate in and out pins
// - bidir bit high: one shared data pin
// - bit six picks lsb or msb first
// - soft reset write restores all defaults
// - soft reset also forces pll relock
// - soft reset bit clears itself, reads zero
// - clocking mode resets to standard 000
// - code 001 selects optional full duplex timing
// - 011 half24 option, 101 half12 option
// - code 111 selects clone clocking
// - bit two makes pin two a clock
// - bit two inverts pin two in full duplex
// - bit one inverts pin three clock
// - transmit analog field offers three power options
// - 100 a off, 010 b off, 111 both
// - both-off option also trims support circuitry
// - bias current never powered down
module serial_port_clock_power_config_regs (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // serial control port
  input wire logic i_cs_n,
  input wire logic i_sclk,
  input wire logic i_serial_data_io,
  output logic o_serial_data_io,
  output logic o_serial_data_io_oe_n,
  output logic o_serial_output_data_pin,
  output logic o_serial_output_data_pin_oe_n,
  // interface clock pins
  input wire logic i_full_duplex_interface,
  input wire logic i_iface_clk,
  output logic o_interface_pin_two,
  output logic o_interface_pin_two_oe_n,
  output logic o_interface_pin_three,
  // clocking status
  output logic [2:0] o_clk_mode,
  output logic [3:0] o_mode_number,
  output logic o_mode_unused,
  output logic o_pll_relock,
  // transmit power control
  output logic o_tx_a_power_down,
  output logic o_tx_b_power_down,
  output logic o_tx_support_power_down,
  output logic o_dac_bias_enable
);
  typedef struct packed {
    spcfg_pkg::cfg_byte_t gen;
    spcfg_pkg::cfg_byte_t clk;
    spcfg_pkg::cfg_byte_t pd;
    logic relock;
  } reg_state_t;

  reg_state_t s_r;
  reg_state_t s_nxt;
  logic wr_stb;
  logic [4:0] addr;
  spcfg_pkg::cfg_byte_t wr_data;
  spcfg_pkg::cfg_byte_t rd_data;
  spcfg_pkg::cfg_byte_t gen_rd;
  logic soft_reset_wr;

  // unmapped addresses read zero; reserved bits are never stored
  function automatic spcfg_pkg::cfg_byte_t read_reg(
    input logic [4:0] a,
    input spcfg_pkg::cfg_byte_t g,
    input spcfg_pkg::cfg_byte_t c,
    input spcfg_pkg::cfg_byte_t p
  );
    case (a)
      `CFG_ADDR_GENERAL: read_reg = g & `CFG_GENERAL_MASK;
      `CFG_ADDR_CLOCKING: read_reg = c & `CFG_CLOCKING_MASK;
      `CFG_ADDR_POWER: read_reg = p & `CFG_POWER_MASK;
      default: read_reg = 8'h00;
    endcase
  endfunction

  serial_shifter u_shifter (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_cs_n(i_cs_n),
    .i_sclk(i_sclk),
    .i_sdio(i_serial_data_io),
    .i_lsb_first(s_r.gen[`CFG_LSB_FIRST_BIT]),
    .i_bidir(s_r.gen[`CFG_BIDIR_BIT]),
    .i_rd_data(rd_data),
    .o_wr_stb(wr_stb),
    .o_addr(addr),
    .o_wr_data(wr_data),
    .o_serial_data_io(o_serial_data_io),
    .o_serial_data_io_oe_n(o_serial_data_io_oe_n),
    .o_serial_output_data_pin(o_serial_output_data_pin),
    .o_serial_output_data_pin_oe_n(o_serial_output_data_pin_oe_n)
  );

  assign rd_data = read_reg(addr, s_r.gen, s_r.clk, s_r.pd);
  assign gen_rd = read_reg(`CFG_ADDR_GENERAL, s_r.gen, s_r.clk, s_r.pd);
  assign soft_reset_wr = wr_stb && (addr == `CFG_ADDR_GENERAL) &&
                         wr_data[`CFG_SOFT_RESET_BIT];

  always_comb begin
    s_nxt = s_r;
    s_nxt.relock = 1'b0;
    if (soft_reset_wr) begin
      // the rest of the written byte is dropped along with everything else
      s_nxt.gen = `CFG_GENERAL_RST;
      s_nxt.clk = `CFG_CLOCKING_RST;
      s_nxt.pd = `CFG_POWER_RST;
      s_nxt.relock = 1'b1;
    end else if (wr_stb) begin
      case (addr)
        `CFG_ADDR_GENERAL: s_nxt.gen = wr_data & `CFG_GENERAL_MASK;
        `CFG_ADDR_CLOCKING: s_nxt.clk = wr_data & `CFG_CLOCKING_MASK;
        `CFG_ADDR_POWER: s_nxt.pd = wr_data & `CFG_POWER_MASK;
        default: s_nxt.relock = 1'b0;
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s_r.gen <= `CFG_GENERAL_RST;
      s_r.clk <= `CFG_CLOCKING_RST;
      s_r.pd <= `CFG_POWER_RST;
      s_r.relock <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  iface_clk_ctrl u_ctrl (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_clk_mode(s_r.clk[`CFG_CLK_MODE_HI:`CFG_CLK_MODE_LO]),
    .i_pin_two_clock_output_enable(s_r.clk[`CFG_PIN2_CLK_EN_BIT]),
    .i_invert_pin_three(s_r.clk[`CFG_PIN3_INV_BIT]),
    .i_tx_analog(s_r.pd[`CFG_TX_ANALOG_HI:`CFG_TX_ANALOG_LO]),
    .i_full_duplex_interface(i_full_duplex_interface),
    .i_iface_clk(i_iface_clk),
    .o_mode_number(o_mode_number),
    .o_mode_unused(o_mode_unused),
    .o_interface_pin_two(o_interface_pin_two),
    .o_interface_pin_two_oe_n(o_interface_pin_two_oe_n),
    .o_interface_pin_three(o_interface_pin_three),
    .o_tx_a_power_down(o_tx_a_power_down),
    .o_tx_b_power_down(o_tx_b_power_down),
    .o_tx_support_power_down(o_tx_support_power_down),
    .o_dac_bias_enable(o_dac_bias_enable)
  );

  assign o_clk_mode = s_r.clk[`CFG_CLK_MODE_HI:`CFG_CLK_MODE_LO];
  assign o_pll_relock = s_r.relock;

  property p_four_wire;
    @(posedge i_clk) disable iff (i_rst)
    !s_r.gen[`CFG_BIDIR_BIT] |-> o_serial_data_io_oe_n;
  endproperty
  a_four_wire: assert property (p_four_wire)
    else $error("shared pin driven in 4-wire mode");

  property p_three_wire;
    @(posedge i_clk) disable iff (i_rst)
    s_r.gen[`CFG_BIDIR_BIT] |-> o_serial_output_data_pin_oe_n;
  endproperty
  a_three_wire: assert property (p_three_wire)
    else $error("dedicated output pin driven in 3-wire mode");

  property p_first_bit;
    @(posedge i_clk) disable iff (i_rst)
    $fell(o_serial_data_io_oe_n && o_serial_output_data_pin_oe_n) |->
      o_serial_output_data_pin == (s_r.gen[`CFG_LSB_FIRST_BIT] ?
        $past(rd_data[0]) : $past(rd_data[7]));
  endproperty
  a_first_bit: assert property (p_first_bit)
    else $error("first read bit not in configured order");

  property p_soft_reset;
    @(posedge i_clk) disable iff (i_rst)
    soft_reset_wr |=> (s_r.gen == `CFG_GENERAL_RST) &&
      (s_r.clk == `CFG_CLOCKING_RST) && (s_r.pd == `CFG_POWER_RST);
  endproperty
  a_soft_reset: assert property (p_soft_reset)
    else $error("soft reset left a register off its default");

  property p_relock;
    @(posedge i_clk) disable iff (i_rst)
    soft_reset_wr |=> o_pll_relock ##1 !o_pll_relock;
  endproperty
  a_relock: assert property (p_relock)
    else $error("relock pulse missing or too long");

  property p_one_shot;
    @(posedge i_clk) disable iff (i_rst)
    wr_stb |=> !s_r.gen[`CFG_SOFT_RESET_BIT] && !gen_rd[`CFG_SOFT_RESET_BIT];
  endproperty
  a_one_shot: assert property (p_one_shot)
    else $error("soft reset bit reads back high");

  property p_standard;
    @(posedge i_clk) disable iff (i_rst)
    (o_clk_mode == `CFG_MODE_STANDARD) [*2] |->
      o_mode_number == `CFG_MODENUM_STANDARD;
  endproperty
  a_standard: assert property (p_standard)
    else $error("standard clocking not decoded");

  property p_opt_full;
    @(posedge i_clk) disable iff (i_rst)
    o_clk_mode == `CFG_MODE_OPT_FULL |=>
      o_mode_number == `CFG_MODENUM_OPT_FULL;
  endproperty
  a_opt_full: assert property (p_opt_full)
    else $error("optional full duplex timing not decoded");

  property p_opt_half;
    @(posedge i_clk) disable iff (i_rst)
    (o_clk_mode == `CFG_MODE_OPT_HALF24 |=>
      o_mode_number == `CFG_MODENUM_OPT_HALF24) and
    (o_clk_mode == `CFG_MODE_OPT_HALF12 |=>
      o_mode_number == `CFG_MODENUM_OPT_HALF12);
  endproperty
  a_opt_half: assert property (p_opt_half)
    else $error("optional half duplex timing not decoded");

  property p_clone;
    @(posedge i_clk) disable iff (i_rst)
    o_clk_mode == `CFG_MODE_CLONE |=> o_mode_number == `CFG_MODENUM_CLONE;
  endproperty
  a_clone: assert property (p_clone)
    else $error("clone clocking not decoded");

  property p_pin_two;
    @(posedge i_clk) disable iff (i_rst)
    $rose(s_r.clk[`CFG_PIN2_CLK_EN_BIT]) |->
      o_interface_pin_two_oe_n ##1 !o_interface_pin_two_oe_n;
  endproperty
  a_pin_two: assert property (p_pin_two)
    else $error("pin two not enabled one cycle after the write");

  property p_pin_two_inv;
    @(posedge i_clk) disable iff (i_rst)
    $past(s_r.clk[`CFG_PIN2_CLK_EN_BIT] && i_full_duplex_interface) |->
      o_interface_pin_two == !$past(i_iface_clk);
  endproperty
  a_pin_two_inv: assert property (p_pin_two_inv)
    else $error("pin two clock not inverted in full duplex");

  property p_pin_two_plain;
    @(posedge i_clk) disable iff (i_rst)
    !(s_r.clk[`CFG_PIN2_CLK_EN_BIT] && i_full_duplex_interface) |=>
      o_interface_pin_two == $past(i_iface_clk);
  endproperty
  a_pin_two_plain: assert property (p_pin_two_plain)
    else $error("pin two clock inverted outside full duplex");

  property p_pin_three;
    @(posedge i_clk) disable iff (i_rst)
    ##1 o_interface_pin_three ==
      ($past(i_iface_clk) ^ $past(s_r.clk[`CFG_PIN3_INV_BIT]));
  endproperty
  a_pin_three: assert property (p_pin_three)
    else $error("pin three polarity wrong");

  property p_tx_both;
    @(posedge i_clk) disable iff (i_rst)
    s_r.pd[`CFG_TX_ANALOG_HI:`CFG_TX_ANALOG_LO] == `CFG_TX_PD_BOTH |=>
      o_tx_a_power_down && o_tx_b_power_down && o_tx_support_power_down;
  endproperty
  a_tx_both: assert property (p_tx_both)
    else $error("both-channel power-down incomplete");

  property p_tx_single;
    @(posedge i_clk) disable iff (i_rst)
    s_r.pd[`CFG_TX_ANALOG_HI:`CFG_TX_ANALOG_LO] == `CFG_TX_PD_A |=>
      o_tx_a_power_down && !o_tx_b_power_down && !o_tx_support_power_down;
  endproperty
  a_tx_single: assert property (p_tx_single)
    else $error("channel a power-down decoded wrongly");

  property p_tx_b;
    @(posedge i_clk) disable iff (i_rst)
    s_r.pd[`CFG_TX_ANALOG_HI:`CFG_TX_ANALOG_LO] == `CFG_TX_PD_B |=>
      !o_tx_a_power_down && o_tx_b_power_down && !o_tx_support_power_down;
  endproperty
  a_tx_b: assert property (p_tx_b)
    else $error("channel b power-down decoded wrongly");

  property p_bias;
    @(posedge i_clk) disable iff (i_rst)
    o_dac_bias_enable;
  endproperty
  a_bias: assert property (p_bias)
    else $error("bias current switched off");

  c_soft_reset: cover property (@(posedge i_clk) disable iff (i_rst)
    soft_reset_wr);
  c_three_wire_read: cover property (@(posedge i_clk) disable iff (i_rst)
    !o_serial_data_io_oe_n);
  c_lsb_write: cover property (@(posedge i_clk) disable iff (i_rst)
    wr_stb && s_r.gen[`CFG_LSB_FIRST_BIT]);
  c_clone: cover property (@(posedge i_clk) disable iff (i_rst)
    o_mode_number == `CFG_MODENUM_CLONE);
  c_tx_both: cover property (@(posedge i_clk) disable iff (i_rst)
    o_tx_support_power_down);
endmodule

/* rtl/serial_shifter.sv */
// serial control port shift engine: instruction, data and read-back bits
`timescale 1ns/1ps
`include "spcfg_cfg.svh"
module serial_shifter (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // serial pins, sampled on i_clk
  input wire logic i_cs_n,
  input wire logic i_sclk,
  input wire logic i_sdio,
  // port configuration
  input wire logic i_lsb_first,
  input wire logic i_bidir,
  // register side
  input wire logic [7:0] i_rd_data,
  output logic o_wr_stb,
  output logic [4:0] o_addr,
  output logic [7:0] o_wr_data,
  // pin drivers
  output logic o_serial_data_io,
  output logic o_serial_data_io_oe_n,
  output logic o_serial_output_data_pin,
  output logic o_serial_output_data_pin_oe_n
);
  typedef struct packed {
    logic sclk_q;
    spcfg_pkg::serial_phase_t phase;
    logic [2:0] cnt;
    spcfg_pkg::cfg_byte_t sh;
    logic rd;
    logic [4:0] addr;
    logic load;
    logic drive;
    spcfg_pkg::cfg_byte_t osh;
    logic obit;
    logic wr_stb;
    spcfg_pkg::cfg_byte_t wr_data;
  } shift_state_t;

  shift_state_t s_r;
  shift_state_t s_nxt;
  logic rise;
  logic fall;
  spcfg_pkg::cfg_byte_t sh_in;

  always_comb begin
    s_nxt = s_r;
    s_nxt.wr_stb = 1'b0;
    s_nxt.load = 1'b0;
    s_nxt.sclk_q = i_sclk;
    rise = !s_r.sclk_q && i_sclk;
    fall = s_r.sclk_q && !i_sclk;
    // bit order applies to instruction and data alike
    sh_in = i_lsb_first ? {i_sdio, s_r.sh[7:1]} : {s_r.sh[6:0], i_sdio};
    if (i_cs_n) begin
      s_nxt.phase = spcfg_pkg::PH_INSTR;
      s_nxt.cnt = 3'h0;
      s_nxt.drive = 1'b0;
      s_nxt.rd = 1'b0;
    end else begin
      if (s_r.load) begin
        s_nxt.osh = i_rd_data;
        s_nxt.obit = i_lsb_first ? i_rd_data[0] : i_rd_data[7];
        s_nxt.drive = 1'b1;
      end else if (fall && s_r.drive) begin
        s_nxt.osh = i_lsb_first ? {1'b0, s_r.osh[7:1]} :
                                  {s_r.osh[6:0], 1'b0};
        s_nxt.obit = i_lsb_first ? s_r.osh[1] : s_r.osh[6];
      end
      if (rise && s_r.phase != spcfg_pkg::PH_DONE) begin
        s_nxt.sh = sh_in;
        s_nxt.cnt = s_r.cnt + 3'h1;
        if (s_r.cnt == `CFG_LAST_BIT) begin
          if (s_r.phase == spcfg_pkg::PH_INSTR) begin
            s_nxt.rd = sh_in[`CFG_INSTR_RD_BIT];
            s_nxt.addr = sh_in[`CFG_INSTR_ADDR_HI:0];
            s_nxt.load = sh_in[`CFG_INSTR_RD_BIT];
            s_nxt.phase = spcfg_pkg::PH_DATA;
          end else begin
            s_nxt.wr_stb = !s_r.rd;
            s_nxt.wr_data = sh_in;
            s_nxt.phase = spcfg_pkg::PH_DONE;
          end
        end
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_wr_stb = s_r.wr_stb;
  assign o_addr = s_r.addr;
  assign o_wr_data = s_r.wr_data;
  assign o_serial_data_io = s_r.obit;
  assign o_serial_output_data_pin = s_r.obit;
  // read data leave on the shared pin or the dedicated pin
  assign o_serial_data_io_oe_n = !(s_r.drive && i_bidir);
  assign o_serial_output_data_pin_oe_n = !(s_r.drive && !i_bidir);
endmodule

/* rtl/spcfg_cfg.svh */
// offsets, field positions, codes and reset values of the configuration bank
`ifndef SPCFG_CFG_SVH
`define SPCFG_CFG_SVH

`define CFG_ADDR_W 5
`define CFG_DATA_W 8
`define CFG_LAST_BIT 3'h7

`define CFG_ADDR_GENERAL 5'h00
`define CFG_ADDR_CLOCKING 5'h01
`define CFG_ADDR_POWER 5'h02

`define CFG_INSTR_RD_BIT 7
`define CFG_INSTR_ADDR_HI 4

`define CFG_BIDIR_BIT 7
`define CFG_LSB_FIRST_BIT 6
`define CFG_SOFT_RESET_BIT 5
`define CFG_CLK_MODE_HI 7
`define CFG_CLK_MODE_LO 5
`define CFG_PIN2_CLK_EN_BIT 2
`define CFG_PIN3_INV_BIT 1
`define CFG_TX_ANALOG_HI 7
`define CFG_TX_ANALOG_LO 5

`define CFG_GENERAL_RST 8'h00
`define CFG_CLOCKING_RST 8'h00
`define CFG_POWER_RST 8'h00
`define CFG_GENERAL_MASK 8'hc0
`define CFG_CLOCKING_MASK 8'he6
`define CFG_POWER_MASK 8'hfe

`define CFG_MODE_STANDARD 3'h0
`define CFG_MODE_OPT_FULL 3'h1
`define CFG_MODE_OPT_HALF24 3'h3
`define CFG_MODE_OPT_HALF12 3'h5
`define CFG_MODE_CLONE 3'h7

`define CFG_MODENUM_UNUSED 4'h0
`define CFG_MODENUM_STANDARD 4'h1
`define CFG_MODENUM_OPT_FULL 4'h2
`define CFG_MODENUM_OPT_HALF24 4'h5
`define CFG_MODENUM_OPT_HALF12 4'h8
`define CFG_MODENUM_CLONE 4'ha

`define CFG_TX_PD_A 3'h4
`define CFG_TX_PD_B 3'h2
`define CFG_TX_PD_BOTH 3'h7

`endif

/* rtl/spcfg_pkg.sv */
// types shared by the configuration bank modules
package spcfg_pkg;
  typedef enum logic [1:0] {
    PH_INSTR,
    PH_DATA,
    PH_DONE
  } serial_phase_t;
  typedef logic [7:0] cfg_byte_t;
endpackage

/* testbench/spi_host_model.sv */
// host controller model driving the serial control port
`timescale 1ns/1ps
module spi_host_model (
  // clock
  input wire logic i_clk,
  // device pin drivers
  input wire logic i_sdio_dut,
  input wire logic i_sdio_oe_n,
  input wire logic i_sdo,
  input wire logic i_sdo_oe_n,
  // lines seen by the device
  output logic o_cs_n,
  output logic o_sclk,
  output logic o_sdio,
  // count of dedicated-pin drives in 3-wire mode and shared-pin drives in 4-wire mode while the host drives
  output int o_bad
);
  logic host_en = 1'b1;
  logic host_bit = 1'b0;
  logic bidir_r = 1'b0;
  logic last_sdio = 1'b0;
  logic last_sdo = 1'b0;
  logic cs_n_q = 1'b1;
  logic sclk_q = 1'b0;
  int bad_n = 0;
  logic sdo_line;
  assign o_cs_n = cs_n_q;
  assign o_sclk = sclk_q;
  assign o_bad = bad_n;
  // a released line shows the inverse of its last level, never a stale copy
  assign o_sdio = !i_sdio_oe_n ? i_sdio_dut :
                  (host_en ? host_bit : ~last_sdio);
  assign sdo_line = !i_sdo_oe_n ? i_sdo : ~last_sdo;
  always @(posedge i_clk) begin
    last_sdio <= o_sdio;
    last_sdo <= sdo_line;
    if ((bidir_r && !i_sdo_oe_n) ||
        (!bidir_r && !i_sdio_oe_n && host_en)) begin
      bad_n <= bad_n + 1;
    end
  end
  // one instruction byte and one data byte per chip select
  task automatic xfer(input logic rd, input logic [4:0] addr,
      input logic [7:0] wdata, input logic lsb, input logic bidir,
      output logic [7:0] rdata);
    logic [15:0] word;
    int k;
    word = {rd, 2'b00, addr, wdata};
    rdata = 8'h00;
    bidir_r = bidir;
    cs_n_q = 1'b0;
    for (int i = 0; i < 16; i++) begin
      k = lsb ? ((i < 8) ? 8 + i : i - 8) : 15 - i;
      // a read bit stands only until the device sees the next sclk fall
      if (rd && i >= 8) begin
        rdata[k] = bidir ? o_sdio : sdo_line;
      end
      sclk_q = 1'b0;
      host_bit = word[k];
      repeat (4) @(negedge i_clk);
      sclk_q = 1'b1;
      @(negedge i_clk);
      // release before the device turns the shared pin round
      if (rd && i == 7) begin
        host_en = 1'b0;
      end
      repeat (3) @(negedge i_clk);
    end
    sclk_q = 1'b0;
    repeat (4) @(negedge i_clk);
    cs_n_q = 1'b1;
    repeat (4) @(negedge i_clk);
    host_en = 1'b1;
  endtask
endmodule

/* testbench/tb_serial_port_clock_power_config_regs.sv */
// self-checking bench for the serial configuration register bank
`timescale 1ns/1ps
module tb_serial_port_clock_power_config_regs;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic fd = 1'b0;
  logic ifc = 1'b0;
  logic lsb = 1'b0;
  logic bidir = 1'b0;
  logic cs_n, sclk, sdio_w, sdio_o, sdio_oe_n, serial_output_data_pin, sdo_oe_n;
  logic pin2, pin2_oe_n, pin3, unused, relock, tx_a, tx_b, tx_s, bias;
  logic [2:0] clk_mode;
  logic [3:0] mode_num;
  logic [3:0] mn [8] = '{4'h1, 4'h2, 4'h0, 4'h5, 4'h0, 4'h8, 4'h0, 4'ha};
  int bad;
  int errors = 0;
  int n_compared = 0;
  int relock_n = 0;

  serial_port_clock_power_config_regs i_dut (
    .i_clk(i_clk), .i_rst(i_rst), .i_cs_n(cs_n), .i_sclk(sclk),
    .i_serial_data_io(sdio_w), .o_serial_data_io(sdio_o),
    .o_serial_data_io_oe_n(sdio_oe_n), .o_serial_output_data_pin(serial_output_data_pin),
    .o_serial_output_data_pin_oe_n(sdo_oe_n),
    .i_full_duplex_interface(fd), .i_iface_clk(ifc),
    .o_interface_pin_two(pin2), .o_interface_pin_two_oe_n(pin2_oe_n),
    .o_interface_pin_three(pin3), .o_clk_mode(clk_mode),
    .o_mode_number(mode_num), .o_mode_unused(unused),
    .o_pll_relock(relock), .o_tx_a_power_down(tx_a),
    .o_tx_b_power_down(tx_b), .o_tx_support_power_down(tx_s),
    .o_dac_bias_enable(bias));

  spi_host_model i_host (
    .i_clk(i_clk), .i_sdio_dut(sdio_o), .i_sdio_oe_n(sdio_oe_n),
    .i_sdo(serial_output_data_pin), .i_sdo_oe_n(sdo_oe_n), .o_cs_n(cs_n), .o_sclk(sclk),
    .o_sdio(sdio_w), .o_bad(bad));

  initial begin
    forever #5 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    if (relock === 1'b1) relock_n++;
  end

  task automatic print_verdict();
    $display("compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
      input string what);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [7:0] dummy;
    i_host.xfer(1'b0, a, d, lsb, bidir, dummy);
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] exp);
    logic [7:0] got;
    i_host.xfer(1'b1, a, 8'h00, lsb, bidir, got);
    chk(got, exp, "read data");
  endtask

  task automatic t_reset();
    rd(5'h00, 8'h00);
    rd(5'h01, 8'h00);
    rd(5'h02, 8'h00);
    chk(8'(mode_num), 8'h01, "mode number");
    chk(8'(bias), 8'h01, "bias");
    chk(8'(pin2_oe_n), 8'h01, "pin two enable");
    chk(8'({tx_a, tx_b, tx_s}), 8'h00, "tx power");
  endtask
  task automatic t_modes();
    for (int c = 0; c < 8; c++) begin
      // the host never programs the unused codes
      if (mn[c] == 4'h0) continue;
      wr(5'h01, {c[2:0], 5'h00});
      chk(8'(clk_mode), 8'(c[2:0]), "clock mode");
      chk(8'(mode_num), 8'(mn[c]), "mode number");
      chk(8'(unused), 8'h00, "unused code");
      rd(5'h01, {c[2:0], 5'h00});
    end
  endtask
  task automatic t_pins();
    wr(5'h01, 8'h06);
    chk(8'(pin2_oe_n), 8'h00, "pin two enable");
    for (int f = 0; f < 2; f++) begin
      for (int v = 0; v < 2; v++) begin
        fd = f[0];
        ifc = v[0];
        repeat (2) @(negedge i_clk);
        chk(8'(pin2), 8'(v[0] ^ f[0]), "pin two clock");
        // logical not: a bitwise one would be widened before inverting
        chk(8'(pin3), 8'(!v[0]), "pin three clock");
      end
    end
    wr(5'h01, 8'h00);
    chk(8'(pin2_oe_n), 8'h01, "pin two enable");
    chk(8'(pin3), 8'(ifc), "pin three clock");
  endtask
  task automatic t_power();
    for (int c = 0; c < 8; c++) begin
      wr(5'h02, {c[2:0], 5'h00});
      chk(8'(tx_a), 8'(c == 4 || c == 7), "tx a off");
      chk(8'(tx_b), 8'(c == 2 || c == 7), "tx b off");
      chk(8'(tx_s), 8'(c == 7), "support off");
      chk(8'(bias), 8'h01, "bias");
      rd(5'h02, {c[2:0], 5'h00});
    end
  endtask
  task automatic t_reserved();
    wr(5'h01, 8'hff);
    rd(5'h01, 8'he6);
    wr(5'h02, 8'hff);
    rd(5'h02, 8'hfe);
    // unmapped places must not alias onto the bank
    wr(5'h03, 8'hff);
    rd(5'h03, 8'h00);
    rd(5'h1f, 8'h00);
    rd(5'h01, 8'he6);
  endtask
  task automatic t_order();
    wr(5'h00, 8'h40);
    lsb = 1'b1;
    rd(5'h00, 8'h40);
    wr(5'h01, 8'h24);
    rd(5'h01, 8'h24);
    wr(5'h00, 8'hc0);
    bidir = 1'b1;
    rd(5'h00, 8'hc0);
    rd(5'h01, 8'h24);
  endtask
  task automatic t_soft();
    int n;
    wr(5'h02, 8'he0);
    n = relock_n;
    wr(5'h00, 8'h20);
    chk(8'(relock_n - n), 8'h01, "relock pulses");
    lsb = 1'b0;
    bidir = 1'b0;
    rd(5'h00, 8'h00);
    rd(5'h01, 8'h00);
    rd(5'h02, 8'h00);
    chk(8'(mode_num), 8'h01, "mode number");
    chk(8'(tx_s), 8'h00, "support off");
  endtask

  initial begin
    repeat (30000) @(posedge i_clk);
    errors++;
    $display("Error at %0t: run timed out", $time);
    print_verdict();
  end
  initial begin
    repeat (5) @(negedge i_clk);
    i_rst = 1'b0;
    @(negedge i_clk);
    t_reset();
    t_modes();
    t_pins();
    t_power();
    t_reserved();
    t_order();
    t_soft();
    chk(8'(bad), 8'h00, "pin drive");
    print_verdict();
  end
endmodule
